// *** include/bwocr_bus_if.sv ***
// Internal register access bus between the AXI4-Lite front end and the core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface bwocr_bus_if;
    import bwocr_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;

    modport front (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
    modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface : bwocr_bus_if
`default_nettype wire

// *** include/bwocr_pkg.sv ***
// Constants, types and helpers shared by the border/window/OTP command block.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package bwocr_pkg;

    // ==========================================================
    // Bus geometry and responses
    localparam int unsigned ADDR_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Command codes, kept as register indices
    localparam logic [7:0] CMD_OTP_MODE = 8'h39;
    localparam logic [7:0] CMD_RSV_A = 8'h3A;
    localparam logic [7:0] CMD_RSV_B = 8'h3B;
    localparam logic [7:0] CMD_BORDER = 8'h3C;
    localparam logic [7:0] CMD_READ_PLANE = 8'h41;
    localparam logic [7:0] CMD_X_WINDOW = 8'h44;

    // ==========================================================
    // Own offsets and field positions
    localparam logic [11:0] OFF_CMD_PORT = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam int unsigned CMD_PORT_DC_BIT = 8;
    localparam logic [2:0] PIDX_SAT = 3'h7;
    localparam logic [1:0] OTP_MODE_INTERNAL = 2'h3;

    // ==========================================================
    // Values after reset
    localparam logic [1:0] RST_OTP_MODE = 2'h0;
    localparam logic [7:0] RST_BORDER = 8'hC0;
    localparam logic RST_READ_PLANE = 1'b0;
    localparam logic [9:0] RST_X_FIRST = 10'h000;
    localparam logic [9:0] RST_X_LAST = 10'h3BF;
    localparam logic [7:0] RST_CMD = 8'h00;

    // ==========================================================
    // Border drive source and fixed level encodings
    typedef enum logic [1:0] {
        BSRC_GS_TRANSITION,
        BSRC_FIX_LEVEL,
        BSRC_COMMON_ELECTRODE,
        BSRC_HIGH_IMPEDANCE
    } bwocr_border_src_t;

    typedef enum logic [1:0] {
        BLVL_GROUND,
        BLVL_HIGH_SOURCE_LEVEL_ONE,
        BLVL_LOW_SOURCE_LEVEL,
        BLVL_HIGH_SOURCE_LEVEL_TWO
    } bwocr_border_level_t;

    // Byte address of a register given its index
    function automatic logic [ADDR_W-1:0] idx_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : idx_addr

    // Writable address: only the command port
    function automatic logic wr_addr_ok(input logic [ADDR_W-1:0] a);
        return a == OFF_CMD_PORT;
    endfunction : wr_addr_ok

    // Readable addresses: status and the four command registers
    function automatic logic rd_addr_ok(input logic [ADDR_W-1:0] a);
        return (a == OFF_STATUS) || (a == idx_addr(CMD_OTP_MODE))
            || (a == idx_addr(CMD_BORDER)) || (a == idx_addr(CMD_READ_PLANE))
            || (a == idx_addr(CMD_X_WINDOW));
    endfunction : rd_addr_ok

endpackage : bwocr_pkg

// *** rtl/bwocr_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read under way at a time.
// Assumes a master that keeps the AXI4-Lite handshake rules.
`timescale 1ns/1ps
`default_nettype none
module bwocr_axil_slave (
    input wire logic clk, // Clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [bwocr_pkg::ADDR_W-1:0] s_axil_awaddr, // Write address
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Write strobes
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    output logic [1:0] s_axil_bresp, // Write response
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    input wire logic [bwocr_pkg::ADDR_W-1:0] s_axil_araddr, // Read address
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    bwocr_bus_if.front bus // Internal register bus
);
    import bwocr_pkg::*;

    logic aw_held_r, w_held_r, wr_en_r, rd_pend_r;
    logic [ADDR_W-1:0] awaddr_r, araddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic issue;

    // A write issues once address and data are both held
    assign issue = aw_held_r && w_held_r && !s_axil_bvalid;

    // ==========================================================
    // Write address channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axil_awready <= 1'b1;
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axil_awvalid && s_axil_awready) begin
            awaddr_r <= s_axil_awaddr;
            aw_held_r <= 1'b1;
            s_axil_awready <= 1'b0;
        end else if (issue) begin
            aw_held_r <= 1'b0;
        end else if (s_axil_bvalid && s_axil_bready) begin
            s_axil_awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axil_wready <= 1'b1;
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (s_axil_wvalid && s_axil_wready) begin
            wdata_r <= s_axil_wdata;
            wstrb_r <= s_axil_wstrb;
            w_held_r <= 1'b1;
            s_axil_wready <= 1'b0;
        end else if (issue) begin
            w_held_r <= 1'b0;
        end else if (s_axil_bvalid && s_axil_bready) begin
            s_axil_wready <= 1'b1;
        end
    end

    // Write strobe to the core and write response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_r <= 1'b0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= RESP_OKAY;
        end else begin
            wr_en_r <= issue;
            if (issue) begin
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= wr_addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read channels: capture address, then answer from the core mux
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axil_arready <= 1'b1;
            araddr_r <= '0;
            rd_pend_r <= 1'b0;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= '0;
            s_axil_rresp <= RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            araddr_r <= s_axil_araddr;
            rd_pend_r <= 1'b1;
            s_axil_arready <= 1'b0;
        end else if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= rd_addr_ok(araddr_r) ? bus.rd_data : 32'h0000_0000;
            s_axil_rresp <= rd_addr_ok(araddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
            s_axil_arready <= 1'b1;
        end
    end

    // Internal bus drive; address and data stay put until the response
    assign bus.wr_en = wr_en_r;
    assign bus.wr_addr = awaddr_r;
    assign bus.wr_data = wdata_r;
    assign bus.wr_strb = wstrb_r;
    assign bus.rd_addr = araddr_r;

endmodule : bwocr_axil_slave
`default_nettype wire

// *** rtl/bwocr_top.sv ***
// Command interpreter for border drive, RAM read plane, X window and OTP mode.
// Assumes a host that writes command and parameter bytes to the command port
// over AXI4-Lite, and logic downstream that reads the configuration outputs.
//
// Summary of operation
// - Command 39h takes a two-bit mode, 00 normal after reset, 11 internal OTP programming voltage.
// - Command 3Ch takes one border byte that reads C0h after reset, the high impedance setting.
// - Border bits 7:6 pick greyscale transition, fixed level, common electrode or high impedance.
// - Border bits 5:4 pick ground, first high, low or second high source level in fixed mode.
// - Border bits 1:0 pick waveform table 0 to 3 in greyscale mode, table 0 after reset.
// - Command 41h bit 0 picks the read plane, 0 for the 24h plane and 1 for the 26h plane.
// - Command 44h takes four bytes: first address low then bits 9:8, last address the same way.
// - The window first address is zero after reset.
// - The window last address is 3BFh after reset, the full X range.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module bwocr_top (
    input wire logic clk, // Clock, 125 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [bwocr_pkg::ADDR_W-1:0] s_axil_awaddr, // Write address
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Write strobes
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    output logic [1:0] s_axil_bresp, // Write response
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    input wire logic [bwocr_pkg::ADDR_W-1:0] s_axil_araddr, // Read address
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    output logic [1:0] otp_mode, // OTP program mode field
    output logic otp_prog_voltage_on, // Internal programming voltage selected
    output logic [7:0] border_ctrl, // Whole border parameter byte
    output bwocr_pkg::bwocr_border_src_t border_drive_output_src, // Border source
    output bwocr_pkg::bwocr_border_level_t border_drive_output_level, // Fixed level
    output logic [1:0] border_drive_output_lut, // Transition table number
    output logic border_drive_output_hiz, // Border in high impedance
    output logic read_plane, // Plane returned on RAM reads
    output logic [9:0] window_x_first, // X window first address
    output logic [9:0] window_x_last // X window last address
);
    import bwocr_pkg::*;

    // ==========================================================
    // Register bus front end
    bwocr_bus_if bus ();

    bwocr_axil_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .bus(bus)
    );

    // ==========================================================
    // Helper functions

    // Border source held in bits 7:6 of the border byte
    function automatic bwocr_border_src_t border_src_of(input logic [7:0] b);
        return bwocr_border_src_t'(b[7:6]);
    endfunction : border_src_of

    // Fixed level held in bits 5:4 of the border byte
    function automatic bwocr_border_level_t border_level_of(input logic [7:0] b);
        return bwocr_border_level_t'(b[5:4]);
    endfunction : border_level_of

    // ==========================================================
    // Command port decode
    logic port_wr;
    logic port_cmd;
    logic port_par;
    logic [7:0] port_byte;
    logic cmd_open_r;
    logic [7:0] cmd_r;
    logic [2:0] pidx_r;
    logic cmd_known_r;

    // A port write needs both low byte lanes; others are answered but dropped
    assign port_wr = bus.wr_en && (bus.wr_addr == OFF_CMD_PORT) && (&bus.wr_strb[1:0]);
    // Select bit low marks a command byte, high a parameter byte
    assign port_cmd = port_wr && !bus.wr_data[CMD_PORT_DC_BIT];
    assign port_par = port_wr && bus.wr_data[CMD_PORT_DC_BIT] && cmd_open_r;
    assign port_byte = bus.wr_data[7:0];

    // Current command and parameter position; a new command restarts the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_open_r <= 1'b0;
            cmd_r <= RST_CMD;
            pidx_r <= '0;
        end else if (port_cmd) begin
            cmd_open_r <= 1'b1;
            cmd_r <= port_byte;
            pidx_r <= '0;
        end else if (port_par && (pidx_r != PIDX_SAT)) begin
            pidx_r <= pidx_r + 3'h1;
        end
    end

    // Flags whether the current command is one this block stores
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_known_r <= 1'b0;
        end else if (port_cmd) begin
            unique case (port_byte)
                CMD_OTP_MODE,
                CMD_BORDER,
                CMD_READ_PLANE,
                CMD_X_WINDOW: cmd_known_r <= 1'b1;
                // Reserved codes are taken as commands but store nothing
                CMD_RSV_A,
                CMD_RSV_B: cmd_known_r <= 1'b0;
                default: cmd_known_r <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // OTP program mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_mode <= RST_OTP_MODE;
            otp_prog_voltage_on <= 1'b0;
        end else if (port_par && (cmd_r == CMD_OTP_MODE) && (pidx_r == 3'h0)) begin
            // Order of OTP steps is left to the host's reference sequence
            otp_mode <= port_byte[1:0];
            otp_prog_voltage_on <= (port_byte[1:0] == OTP_MODE_INTERNAL);
        end
    end

    // ==========================================================
    // Border waveform control and its decoded fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            border_ctrl <= RST_BORDER;
            border_drive_output_src <= border_src_of(RST_BORDER);
            border_drive_output_level <= border_level_of(RST_BORDER);
            border_drive_output_lut <= RST_BORDER[1:0];
            border_drive_output_hiz <= 1'b1;
        end else if (port_par && (cmd_r == CMD_BORDER) && (pidx_r == 3'h0)) begin
            border_ctrl <= port_byte;
            border_drive_output_src <= border_src_of(port_byte);
            border_drive_output_level <= border_level_of(port_byte);
            border_drive_output_lut <= port_byte[1:0];
            border_drive_output_hiz <= (border_src_of(port_byte) == BSRC_HIGH_IMPEDANCE);
        end
    end

    // ==========================================================
    // Read RAM plane option
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_plane <= RST_READ_PLANE;
        end else if (port_par && (cmd_r == CMD_READ_PLANE) && (pidx_r == 3'h0)) begin
            read_plane <= port_byte[0];
        end
    end

    // ==========================================================
    // X window first address: parameters 0 and 1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_x_first <= RST_X_FIRST;
        end else if (port_par && (cmd_r == CMD_X_WINDOW)) begin
            if (pidx_r == 3'h0) begin
                window_x_first[7:0] <= port_byte;
            end else if (pidx_r == 3'h1) begin
                window_x_first[9:8] <= port_byte[1:0];
            end
        end
    end

    // X window last address: parameters 2 and 3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_x_last <= RST_X_LAST;
        end else if (port_par && (cmd_r == CMD_X_WINDOW)) begin
            if (pidx_r == 3'h2) begin
                window_x_last[7:0] <= port_byte;
            end else if (pidx_r == 3'h3) begin
                window_x_last[9:8] <= port_byte[1:0];
            end
        end
    end

    // ==========================================================
    // Read-back mux; unmapped reads are refused by the front end
    always_comb begin
        bus.rd_data = 32'h0000_0000;
        if (bus.rd_addr == OFF_STATUS) begin
            bus.rd_data = {19'h0_0000, cmd_known_r, cmd_open_r, pidx_r, cmd_r};
        end else if (bus.rd_addr == idx_addr(CMD_OTP_MODE)) begin
            bus.rd_data = {30'h0000_0000, otp_mode};
        end else if (bus.rd_addr == idx_addr(CMD_BORDER)) begin
            bus.rd_data = {24'h00_0000, border_ctrl};
        end else if (bus.rd_addr == idx_addr(CMD_READ_PLANE)) begin
            bus.rd_data = {31'h0000_0000, read_plane};
        end else if (bus.rd_addr == idx_addr(CMD_X_WINDOW)) begin
            bus.rd_data = {6'h00, window_x_last, 6'h00, window_x_first};
        end
    end

endmodule : bwocr_top
`default_nettype wire

// *** testbench/bwocr_host_model.sv ***
// Host model: AXI4-Lite master that writes command and parameter bytes.
// Assumes one clock shared with the block; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module bwocr_host_model (
    input wire logic clk, // Clock
    output logic [bwocr_pkg::ADDR_W-1:0] s_axil_awaddr = '0, // AW address
    output logic s_axil_awvalid = 1'b0, // AW valid
    input wire logic s_axil_awready, // AW ready
    output logic [31:0] s_axil_wdata = '0, // W data
    output logic [3:0] s_axil_wstrb = '0, // W strobes
    output logic s_axil_wvalid = 1'b0, // W valid
    input wire logic s_axil_wready, // W ready
    input wire logic [1:0] s_axil_bresp, // B response
    input wire logic s_axil_bvalid, // B valid
    output logic s_axil_bready = 1'b0, // B ready
    output logic [bwocr_pkg::ADDR_W-1:0] s_axil_araddr = '0, // AR address
    output logic s_axil_arvalid = 1'b0, // AR valid
    input wire logic s_axil_arready, // AR ready
    input wire logic [31:0] s_axil_rdata, // R data
    input wire logic [1:0] s_axil_rresp, // R response
    input wire logic s_axil_rvalid, // R valid
    output logic s_axil_rready = 1'b0 // R ready
);
    import bwocr_pkg::*;
    // Write one word; each channel held until taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_done = 1'b0;
        logic w_done = 1'b0;
        @(posedge clk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_wstrb <= s;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
            aw_done |= s_axil_awready;
            w_done |= s_axil_wready;
        end while (!(aw_done && w_done));
        do @(posedge clk); while (s_axil_bvalid !== 1'b1);
        r = s_axil_bresp;
        s_axil_bready <= 1'b0;
    endtask : wr
    // Read one word and take data and response at the same edge
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do @(posedge clk); while (s_axil_arready !== 1'b1);
        s_axil_arvalid <= 1'b0;
        do @(posedge clk); while (s_axil_rvalid !== 1'b1);
        d = s_axil_rdata;
        r = s_axil_rresp;
        s_axil_rready <= 1'b0;
    endtask : rd
endmodule : bwocr_host_model
`default_nettype wire

// *** testbench/bwocr_props.sv ***
// Checker for the border/window/OTP command block.
// Assumes it is bound onto bwocr_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bwocr_props (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic s_axil_awvalid, // AW valid
    input wire logic s_axil_awready, // AW ready
    input wire logic s_axil_wvalid, // W valid
    input wire logic s_axil_wready, // W ready
    input wire logic s_axil_bvalid, // B valid
    input wire logic s_axil_arvalid, // AR valid
    input wire logic s_axil_arready, // AR ready
    input wire logic s_axil_rvalid, // R valid
    input wire logic [1:0] otp_mode, // OTP mode
    input wire logic otp_prog_voltage_on, // Voltage select
    input wire logic [7:0] border_ctrl, // Border byte
    input wire logic [1:0] border_drive_output_src, // Source
    input wire logic [1:0] border_drive_output_level, // Level
    input wire logic [1:0] border_drive_output_lut, // Table
    input wire logic border_drive_output_hiz, // High impedance
    input wire logic read_plane, // Plane
    input wire logic [9:0] window_x_first, // First address
    input wire logic [9:0] window_x_last // Last address
);
    import bwocr_pkg::*;
    // ==========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    sequence s_rd_taken;
        s_axil_arvalid && s_axil_arready;
    endsequence
    a_reset_values: assert property ($rose(rst_n) |-> border_ctrl == 8'hC0
        && otp_mode == 2'h0 && !read_plane && window_x_first == 10'h000
        && window_x_last == 10'h3BF) else $error("reset value");
    a_volt_mode: assert property (otp_prog_voltage_on == (otp_mode == 2'h3))
        else $error("voltage select");
    a_src_field: assert property (border_drive_output_src == border_ctrl[7:6])
        else $error("border source");
    a_level_field: assert property (border_drive_output_level == border_ctrl[5:4])
        else $error("border level");
    a_lut_field: assert property (border_drive_output_lut == border_ctrl[1:0])
        else $error("border table");
    a_hiz_src: assert property (border_drive_output_hiz == (border_ctrl[7:6] == 2'h3))
        else $error("border hiz");
    a_cfg_after_wr: assert property (!$stable({otp_mode, border_ctrl, read_plane,
        window_x_first, window_x_last}) |-> $past(s_axil_bvalid))
        else $error("config without write");
    a_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axil_bvalid)
        else $error("write late");
    a_rd_answer: assert property (s_rd_taken |-> ##[1:3] s_axil_rvalid)
        else $error("read late");
endmodule : bwocr_props
bind bwocr_top bwocr_props u_props (.*);
`default_nettype wire

// *** testbench/bwocr_tb_top.sv ***
// Self-checking bench for the border/window/OTP command block.
// Assumes the host model drives the bus; reset comes from here.
`timescale 1ns/1ps
`default_nettype none
module bwocr_tb_top;
    import bwocr_pkg::*;
    logic clk;
    logic rst_n;
    logic [ADDR_W-1:0] s_axil_awaddr, s_axil_araddr;
    logic [31:0] s_axil_wdata, s_axil_rdata;
    logic [3:0] s_axil_wstrb;
    logic [1:0] s_axil_bresp, s_axil_rresp, otp_mode, border_drive_output_lut, em;
    logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
    logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
    logic otp_prog_voltage_on, border_drive_output_hiz, read_plane, ep;
    logic [7:0] border_ctrl, eb;
    bwocr_border_src_t border_drive_output_src;
    bwocr_border_level_t border_drive_output_level;
    logic [9:0] window_x_first, window_x_last, ef, el;
    logic [1:0] r;
    int bad_count, cmp_count;
    bwocr_top dut (.*);
    bwocr_host_model host (.*);
    // ==========
    // Helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Command byte with select low, parameter byte with select high
    task automatic send(input logic dc, input logic [7:0] b);
        host.wr(OFF_CMD_PORT, {23'h0, dc, b}, 4'hF, r);
        chk("bresp", RESP_OKAY, r);
    endtask : send
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0] rr;
        host.rd(a, d, rr);
        chk("rdata", e, d);
        chk("rresp", er, rr);
    endtask : rdchk
    // Compare all configuration outputs and the four command register readbacks
    task automatic chk_all;
        repeat (2) @(posedge clk);
        chk("mode", em, otp_mode);
        chk("voltage", em == 2'h3, otp_prog_voltage_on);
        chk("border", eb, border_ctrl);
        chk("border src", eb[7:6], border_drive_output_src);
        chk("border level", eb[5:4], border_drive_output_level);
        chk("border lut", eb[1:0], border_drive_output_lut);
        chk("border hiz", eb[7:6] == 2'h3, border_drive_output_hiz);
        chk("plane", ep, read_plane);
        chk("first", ef, window_x_first);
        chk("last", el, window_x_last);
        rdchk(12'h0E4, em);
        rdchk(12'h0F0, eb);
        rdchk(12'h104, ep);
        rdchk(12'h110, {6'h0, el, 6'h0, ef});
    endtask : chk_all
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        bad_count++;
        conclude;
    end
    // Test sequence
    initial begin
        bad_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        {em, eb, ep, ef, el} = {2'h0, 8'hC0, 1'b0, 10'h000, 10'h3BF};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk_all;
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            {em, ep} = {i[3:2], i[0]};
            eb = {i[3:2], i[1:0], 2'h0, i[1:0]};
            send(1'b0, CMD_OTP_MODE);
            send(1'b1, {6'h0, em});
            send(1'b0, CMD_BORDER);
            send(1'b1, eb);
            send(1'b0, CMD_READ_PLANE);
            send(1'b1, {7'h0, ep});
            chk_all;
        end
        $display("test settings done");
        send(1'b0, CMD_X_WINDOW);
        send(1'b1, 8'hA5);
        send(1'b1, 8'h02);
        send(1'b1, 8'h3C);
        send(1'b1, 8'h03);
        send(1'b1, 8'hFF);
        {ef, el} = {10'h2A5, 10'h33C};
        chk_all;
        send(1'b0, CMD_X_WINDOW);
        send(1'b1, 8'h11);
        ef = 10'h211;
        chk_all;
        $display("test window done");
        send(1'b0, CMD_RSV_A);
        send(1'b1, 8'h00);
        send(1'b0, CMD_RSV_B);
        send(1'b1, 8'h55);
        chk_all;
        rdchk(OFF_STATUS, 32'h0000_093B);
        $display("test reserved done");
        host.wr(12'h0F0, 32'h0, 4'hF, r);
        chk("bresp", RESP_SLVERR, r);
        rdchk(12'h008, 32'h0, RESP_SLVERR);
        host.wr(OFF_CMD_PORT, {24'h0, CMD_BORDER}, 4'h1, r);
        send(1'b1, 8'h00);
        chk_all;
        $display("test refusal done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        send(1'b1, 8'h12);
        {em, eb, ep, ef, el} = {2'h0, 8'hC0, 1'b0, 10'h000, 10'h3BF};
        chk_all;
        $display("test rerun reset done");
        conclude;
    end
endmodule : bwocr_tb_top
`default_nettype wire
